// File: src/tmr2co_defines.vh
// Register offsets, field positions, reset values and timing counts for the timer two block.
`ifndef TMR2CO_DEFINES_VH
`define TMR2CO_DEFINES_VH
`define TMR2CO_ADDR_CONTROL 8'hc8
`define TMR2CO_ADDR_MODE 8'hc9
`define TMR2CO_ADDR_RELOAD_LOW 8'hca
`define TMR2CO_ADDR_RELOAD_HIGH 8'hcb
`define TMR2CO_ADDR_COUNT_LOW 8'hcc
`define TMR2CO_ADDR_COUNT_HIGH 8'hcd
`define TMR2CO_ADDR_IRQ_STATUS 8'hce
`define TMR2CO_ADDR_IRQ_MASK 8'hcf
`define TMR2CO_CTL_OVF 7
`define TMR2CO_CTL_EXT 6
`define TMR2CO_CTL_RCLK 5
`define TMR2CO_CTL_TX_CLOCK_SELECT 4
`define TMR2CO_CTL_EXEN 3
`define TMR2CO_CTL_RUN 2
`define TMR2CO_CTL_CNT 1
`define TMR2CO_CTL_CAP 0
`define TMR2CO_MOD_OE 1
`define TMR2CO_MOD_UPDN 0
`define TMR2CO_CONTROL_RESET 8'h00
`define TMR2CO_MODE_RESET 8'h00
`define TMR2CO_TIMER_PRESCALE 4'hc
`define TMR2CO_CLKOUT_PRESCALE 4'h2
`define TMR2CO_IRQ_OVF 0
`define TMR2CO_IRQ_EXT 1
`endif

// File: src/tmr2co_timer.v
// Timer two with clock-out mode, control register, interrupt status and serial clock select.
//
// Functional notes
// - clock-out gives 50% duty square wave
// - clock-out counts at oscillator over two
// - overflow reloads count from reload registers
// - clock-out overflows raise no interrupt
// - output toggles each overflow, fosc/4(65536-reload)
// - clock drives external clock pin
// - baud and clock-out share reload registers
// - overflow flag set unless serial select or clock-out mode
// - enabled trigger falling edge sets external flag
// - software clears flag; up/down suppresses external interrupt
// - receive select picks this overflow
// - transmit select picks this overflow
// - run bit enables counting
// - counter select picks oscillator or pin edges
// - control resets zero, bit writable
`timescale 1ns/1ns
`include "tmr2co_defines.vh"
module tmr2co_timer
(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register port
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// Pins
	input wire ext_clock_in,
	input wire ext_trigger_in,
	output reg ext_clock_out,
	output reg ext_clock_oe,
	// Serial clock sources
	input wire other_timer_overflow,
	output reg rx_baud_tick,
	output reg tx_baud_tick,
	// Interrupt
	output reg irq
);
	reg [7:0] timer_two_control;
	reg [1:0] timer_two_mode;
	reg [7:0] reload_low;
	reg [7:0] reload_high;
	reg [7:0] count_low;
	reg [7:0] count_high;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;
	reg [3:0] prescale;
	reg clk_pin_d;
	reg trig_d;
	reg [7:0] next_rdata;

	reg [7:0] next_control;
	reg [7:0] next_reload_low;
	reg [7:0] next_reload_high;
	reg [7:0] next_count_low;
	reg [7:0] next_count_high;

	// Field views of the control and mode registers.
	wire overflow_flag = timer_two_control[`TMR2CO_CTL_OVF];
	wire external_flag = timer_two_control[`TMR2CO_CTL_EXT];
	wire rx_clock_select = timer_two_control[`TMR2CO_CTL_RCLK];
	wire tx_clock_select = timer_two_control[`TMR2CO_CTL_TX_CLOCK_SELECT];
	wire external_enable = timer_two_control[`TMR2CO_CTL_EXEN];
	wire run_bit = timer_two_control[`TMR2CO_CTL_RUN];
	wire counter_select = timer_two_control[`TMR2CO_CTL_CNT];
	wire capture_reload_select = timer_two_control[`TMR2CO_CTL_CAP];
	wire clock_output_enable = timer_two_mode[`TMR2CO_MOD_OE];
	wire up_down_enable = timer_two_mode[`TMR2CO_MOD_UPDN];
	// Either serial select puts the timer in baud mode, where the capture select is ignored.
	wire baud_mode = rx_clock_select | tx_clock_select;
	// Clock-out needs the oscillator path; the pin input never drives the fast prescaler.
	wire clkout_mode = clock_output_enable & ~counter_select;
	wire [3:0] prescale_top = clkout_mode ? `TMR2CO_CLKOUT_PRESCALE : `TMR2CO_TIMER_PRESCALE;
	// Greater-or-equal, so a rate change with the prescaler above the new top cannot make it run a full lap.
	wire osc_tick = (prescale >= prescale_top - 4'h1);
	wire pin_fall = clk_pin_d & ~ext_clock_in;
	wire count_tick = run_bit & (counter_select ? pin_fall : osc_tick);
	// run gating
	// The seventeenth bit is the carry out of ffff and marks the overflow.
	wire [16:0] count_sum = {1'b0, count_high, count_low} + 17'h00001;
	wire overflow = count_tick & count_sum[16];
	wire trig_fall = external_enable & trig_d & ~ext_trigger_in;
	wire do_capture = trig_fall & capture_reload_select & ~baud_mode;
	wire do_ext_reload = trig_fall & ~(capture_reload_select & ~baud_mode);
	wire wr_ctl = wr & (addr == `TMR2CO_ADDR_CONTROL);
	wire wr_mode = wr & (addr == `TMR2CO_ADDR_MODE);
	wire wr_mask = wr & (addr == `TMR2CO_ADDR_IRQ_MASK);
	wire wr_rel_low = wr & (addr == `TMR2CO_ADDR_RELOAD_LOW);
	wire wr_rel_high = wr & (addr == `TMR2CO_ADDR_RELOAD_HIGH);
	wire wr_cnt_low = wr & (addr == `TMR2CO_ADDR_COUNT_LOW);
	wire wr_cnt_high = wr & (addr == `TMR2CO_ADDR_COUNT_HIGH);
	wire wr_status = wr & (addr == `TMR2CO_ADDR_IRQ_STATUS);

	wire set_ovf = overflow & ~baud_mode & ~clkout_mode;
	// no overflow interrupt event in clock-out mode
	wire ovf_event = set_ovf;
	// up/down mode gives no external interrupt
	// Up/down counting itself is not built; its enable only silences the external interrupt.
	wire ext_event = trig_fall & ~up_down_enable;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			prescale <= 4'h0;
		else
			prescale <= osc_tick ? 4'h0 : prescale + 4'h1;
	end

	// Pin samples reset to the idle high level, so no false edge follows reset.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clk_pin_d <= 1'b1;
			trig_d <= 1'b1;
		end
		else
		begin
			clk_pin_d <= ext_clock_in;
			trig_d <= ext_trigger_in;
		end
	end

	// Control register; hardware set wins over a software write.
	always @*
	begin
		next_control = timer_two_control;
		if (wr_ctl)
			next_control = wdata;
		if (set_ovf)
			next_control[`TMR2CO_CTL_OVF] = 1'b1;
		if (trig_fall)
			next_control[`TMR2CO_CTL_EXT] = 1'b1;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			timer_two_control <= `TMR2CO_CONTROL_RESET;
		else
			timer_two_control <= next_control;
	end

	// Mode and mask registers.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			timer_two_mode <= 2'h0;
			irq_mask <= 2'h0;
		end
		else
		begin
			if (wr_mode)
				timer_two_mode <= wdata[1:0];
			if (wr_mask)
				irq_mask <= wdata[1:0];
		end
	end

	always @*
	begin
		next_reload_low = reload_low;
		next_reload_high = reload_high;
		if (do_capture)
		begin
			next_reload_low = count_low;
			next_reload_high = count_high;
		end
		else
		begin
			if (wr_rel_low)
				next_reload_low = wdata;
			if (wr_rel_high)
				next_reload_high = wdata;
		end
	end

	// A capture wins over a software reload write in the same cycle, so no trigger event is lost.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			reload_low <= 8'h00;
			reload_high <= 8'h00;
		end
		else
		begin
			reload_low <= next_reload_low;
			reload_high <= next_reload_high;
		end
	end

	// Counter next value; a hardware reload takes priority over a software count write.
	always @*
	begin
		next_count_low = count_low;
		next_count_high = count_high;
		// reload on overflow, shared by baud and clock-out
		if (overflow | do_ext_reload)
		begin
			next_count_low = reload_low;
			next_count_high = reload_high;
		end
		// A count write in an overflow cycle is lost; stop the timer before loading the count.
		else if (wr_cnt_low | wr_cnt_high)
		begin
			if (wr_cnt_low)
				next_count_low = wdata;
			if (wr_cnt_high)
				next_count_high = wdata;
		end
		else if (count_tick)
		begin
			next_count_low = count_sum[7:0];
			next_count_high = count_sum[15:8];
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count_low <= 8'h00;
			count_high <= 8'h00;
		end
		else
		begin
			count_low <= next_count_low;
			count_high <= next_count_high;
		end
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			ext_clock_oe <= 1'b0;
		else
			ext_clock_oe <= clock_output_enable;
	end

	// The pin only ever toggles, so both halves last one overflow period each.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			ext_clock_out <= 1'b0;
		else if (clkout_mode & overflow)
			ext_clock_out <= ~ext_clock_out;
	end

	// Serial clock sources, registered so that the outputs are free of glitches.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_baud_tick <= 1'b0;
			tx_baud_tick <= 1'b0;
		end
		else
		begin
			rx_baud_tick <= rx_clock_select ? overflow : other_timer_overflow;
			tx_baud_tick <= tx_clock_select ? overflow : other_timer_overflow;
		end
	end

	// Sticky status, write one to clear; a new event wins over the clear.
	wire [1:0] status_event = {ext_event, ovf_event};
	wire [1:0] status_clear = {2{wr_status}} & wdata[1:0];
	wire [1:0] next_irq_status;
	genvar bit_idx;
	generate
		for (bit_idx = 0; bit_idx < 2; bit_idx = bit_idx + 1)
		begin : g_status
			assign next_irq_status[bit_idx] = status_event[bit_idx] | (irq_status[bit_idx] & ~status_clear[bit_idx]);
		end
	endgenerate

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			irq_status <= 2'h0;
			irq <= 1'b0;
		end
		else
		begin
			irq_status <= next_irq_status;
			irq <= |(irq_status & irq_mask);
		end
	end

	// Unmapped addresses read as zero.
	always @*
	begin
		case (addr)
			`TMR2CO_ADDR_CONTROL: next_rdata = timer_two_control;
			`TMR2CO_ADDR_MODE: next_rdata = {6'h00, timer_two_mode};
			`TMR2CO_ADDR_RELOAD_LOW: next_rdata = reload_low;
			`TMR2CO_ADDR_RELOAD_HIGH: next_rdata = reload_high;
			`TMR2CO_ADDR_COUNT_LOW: next_rdata = count_low;
			`TMR2CO_ADDR_COUNT_HIGH: next_rdata = count_high;
			`TMR2CO_ADDR_IRQ_STATUS: next_rdata = {6'h00, irq_status};
			`TMR2CO_ADDR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data stand for one cycle only and read zero otherwise, so stale values never linger on the bus.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else
			rdata <= rd ? next_rdata : 8'h00;
	end
endmodule // tmr2co_timer

// File: dv/tmr2co_clk_sink.sv
// Receiver of the generated clock; measures its half period.
`timescale 1ns/1ns
module tmr2co_clk_sink
(
	// Clock
	input wire clk,
	// Pin drive
	input wire drv,
	input wire oe,
	input wire ext,
	// Pin level and half period in clocks
	output wire pin,
	output reg [15:0] half = 16'h0000
);
	reg [15:0] cnt = 16'h0000;
	reg last = 1'b1;
	assign pin = oe ? drv : ext;
	always @(posedge clk)
	begin
		cnt <= (pin != last) ? 16'h0001 : cnt + 16'h0001;
		if (pin != last)
			half <= cnt;
		last <= pin;
	end
endmodule // tmr2co_clk_sink

// File: dv/tmr2co_timer_assertions.sv
// Checker on the timer two ports.
`timescale 1ns/1ns
module tmr2co_chk
(
	// Clock and register port
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	// Pins, ticks, interrupt
	input wire ext_clock_out,
	input wire ext_clock_oe,
	input wire other_timer_overflow,
	input wire rx_baud_tick,
	input wire tx_baud_tick,
	input wire irq
);
	reg [1:0] sel;
	reg [7:0] msk;
	wire mw = wr && addr == 8'hc9;
	// Shadows of software-only fields, since the ports do not show them.
	always @(posedge clk or posedge rst)
		if (rst)
		begin
			sel <= 2'h0;
			msk <= 8'h00;
		end
		else
		begin
			if (wr && addr == 8'hc8)
				sel <= wdata[5:4];
			if (wr && addr == 8'hcf)
				msk <= wdata;
		end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rx; !sel[1] |=> rx_baud_tick == $past(other_timer_overflow); endproperty
	a_rx: assert property (p_rx) else $error("rx tick wrong");
	property p_tx; !sel[0] |=> tx_baud_tick == $past(other_timer_overflow); endproperty
	a_tx: assert property (p_tx) else $error("tx tick wrong");
	property p_sel; rd && addr == 8'hc8 |=> rdata[5:4] == sel; endproperty
	a_sel: assert property (p_sel) else $error("select readback");
	property p_unm; rd && addr < 8'hc8 |=> rdata == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_oe; !$past(mw) && !$past(mw, 2) |-> $stable(ext_clock_oe); endproperty
	a_oe: assert property (p_oe) else $error("enable moved");
	property p_gap; $changed(ext_clock_out) |=> $stable(ext_clock_out); endproperty
	a_gap: assert property (p_gap) else $error("clock too fast");
	property p_msk; msk == 8'h00 |=> !irq; endproperty
	a_msk: assert property (p_msk) else $error("masked irq");
	property p_rst; disable iff (1'b0) rst |-> !irq && !ext_clock_oe && rdata == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	c_out: cover property ($rose(ext_clock_out) && ext_clock_oe);
	c_irq: cover property ($rose(irq));
	c_tx: cover property (tx_baud_tick);
endmodule // tmr2co_chk
bind tmr2co_timer tmr2co_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .ext_clock_out(ext_clock_out), .ext_clock_oe(ext_clock_oe), .irq(irq),
	.other_timer_overflow(other_timer_overflow), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick));

// File: dv/tmr2co_timer_tb_top.sv
// Self-checking bench for timer two.
`timescale 1ns/1ns
module tmr2co_timer_tb_top;
	reg clk = 1'b0;
	reg rst = 1'b0;
	reg ext_lvl = 1'b1;
	integer rx_ticks = 0;
	integer tx_ticks = 0;
	reg [7:0] addr = 8'h00;
	reg [7:0] wdata = 8'h00;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg trig = 1'b1;
	reg oto = 1'b0;
	wire [7:0] rdata;
	wire out, oe, pin, rxt, txt, irq;
	wire [15:0] half;
	integer mismatches = 0;
	integer num_checks = 0;
	integer cyc = 0;
	integer i;
	always #50 clk = ~clk;
	tmr2co_timer DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ext_clock_in(pin), .ext_trigger_in(trig), .ext_clock_out(out), .ext_clock_oe(oe),
		.other_timer_overflow(oto), .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq(irq));
	tmr2co_clk_sink u_sink (.clk(clk), .drv(out), .oe(oe), .ext(ext_lvl), .pin(pin), .half(half));
	always @(posedge clk)
	begin
		rx_ticks = rx_ticks + rxt;
		tx_ticks = tx_ticks + txt;
	end
	task chk(input string nm, input [15:0] e, input [15:0] g);
	begin
		num_checks = num_checks + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task wreg(input [7:0] a, input [7:0] d);
	begin
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rreg(input [7:0] a, input [7:0] e);
	begin
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", {8'h00, e}, {8'h00, rdata});
	end
	endtask
	task end_of_test;
	begin
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 6000)
		begin
			mismatches = mismatches + 1;
			end_of_test;
		end
	end
	initial
	begin
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rreg(8'hc8, 8'h00);
		rreg(8'h10, 8'h00);
		wreg(8'hc8, 8'h30);
		rreg(8'hc8, 8'h30);
		wreg(8'hc8, 8'h00);
		@(posedge clk) oto <= 1'b1;
		@(posedge clk) oto <= 1'b0;
		#1 chk("tx", 16'h0001, {15'h0000, txt});
		chk("rx", 16'h0001, {15'h0000, rxt});
		wreg(8'hcf, 8'h03);
		wreg(8'hca, 8'he0);
		wreg(8'hcb, 8'hff);
		wreg(8'hcc, 8'hfe);
		wreg(8'hcd, 8'hff);
		wreg(8'hc8, 8'h04);
		repeat (40) @(posedge clk);
		rreg(8'hc8, 8'h84);
		chk("irq", 16'h0001, {15'h0000, irq});
		wreg(8'hce, 8'h01);
		wreg(8'hc8, 8'h00);
		@(posedge clk) trig <= 1'b0;
		rreg(8'hc8, 8'h00);
		for (i = 0; i < 2; i = i + 1)
		begin
			wreg(8'hc9, {7'h00, i[0]});
			@(posedge clk) trig <= 1'b1;
			wreg(8'hc8, 8'h08);
			@(posedge clk) trig <= 1'b0;
			rreg(8'hc8, 8'h48);
			rreg(8'hce, i[0] ? 8'h00 : 8'h02);
			chk("irq", {15'h0000, ~i[0]}, {15'h0000, irq});
			wreg(8'hce, 8'h02);
			wreg(8'hc8, 8'h00);
		end
		wreg(8'hcc, 8'h10);
		wreg(8'hc8, 8'h06);
		for (i = 0; i < 3; i = i + 1)
		begin
			@(posedge clk) ext_lvl <= 1'b0;
			@(posedge clk) ext_lvl <= 1'b1;
		end
		wreg(8'hc8, 8'h00);
		rreg(8'hcc, 8'h13);
		@(posedge clk) trig <= 1'b1;
		wreg(8'hc8, 8'h09);
		@(posedge clk) trig <= 1'b0;
		rreg(8'hca, 8'h13);
		wreg(8'hce, 8'h02);
		wreg(8'hc8, 8'h00);
		wreg(8'hca, 8'he0);
		wreg(8'hc9, 8'h02);
		wreg(8'hcc, 8'he0);
		wreg(8'hc8, 8'h04);
		repeat (400) @(posedge clk);
		chk("half", 16'h0040, half);
		chk("oe", 16'h0001, {15'h0000, oe});
		rreg(8'hce, 8'h00);
		wreg(8'hc8, 8'h34);
		@(posedge clk);
		#1 rx_ticks = 0;
		tx_ticks = 0;
		repeat (256) @(posedge clk);
		#1 chk("rx ticks", 16'h0004, rx_ticks[15:0]);
		chk("tx ticks", 16'h0004, tx_ticks[15:0]);
		repeat (44) @(posedge clk);
		chk("half", 16'h0040, half);
		rreg(8'hc8, 8'h34);
		end_of_test;
	end
endmodule // tmr2co_timer_tb_top
